// File: src/cmc_mode_ctrl.sv
// CAN operating-mode controller: mode request and acknowledge, pin ownership,
// write protection, error counter handling, abort and listen-all capture.
// Assumes a protocol engine beside it that reports busy/error events and a bit strobe.
`timescale 1ns/1ns
`default_nettype none
`include "cmc_regs.svh"

module cmc_mode_ctrl #(
	parameter int IDLE_BITS = `CMC_IDLE_BITS,
	parameter int WAKE_FILT = `CMC_WAKE_FILT
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Register port
	input  wire cmc_pkg::cmc_bus_t bus,
	output logic [15:0]           rdata,
	// Protocol engine side
	input  wire cmc_pkg::cmc_eng_t eng,
	input  wire logic             bit_stb,
	input  wire logic             eng_tx,
	input  wire logic             err_tx_inc,
	input  wire logic             err_rx_inc,
	input  wire logic             sleep,
	output logic                  eng_rx,
	output logic                  tx_allow,
	output logic                  rx_allow,
	output logic                  err_ack_allow,
	output logic                  tx_start,
	output logic                  ignore_err,
	// Pins
	input  wire logic             bus_receive_pin,
	output logic                  bus_transmit_pin,
	output logic                  tx_pin_own,
	output logic                  rx_pin_own
);
	import cmc_pkg::*;

	initial begin
		if (WAKE_FILT < 1 || WAKE_FILT > 15)
			$error("cmc_mode_ctrl: WAKE_FILT out of range");
	end

	// Whole state of the block
	typedef struct packed {
		logic [2:0]  mode_request_field;   // Requested mode
		cmc_mode_t   mode;                 // Mode in effect
		logic        wake_filter_enable;   // Receive filter in sleep
		logic        wake_event_flag;      // Bus activity while disabled
		logic        transmit_request_flag;
		logic        transmit_aborted_flag;
		logic        tx_wait;              // Waiting for idle before first frame
		logic [7:0]  wait_cnt;             // Recessive run since the mode was entered
		logic [7:0]  tec;                  // Transmit error count
		logic [7:0]  rec;                  // Receive error count
		logic [15:0] rx_capture;           // Partial frame held for software
		logic        rx_cap_full;
		logic [3:0]  filt_cnt;             // Wake filter run length
		logic        filt_level;           // Filtered receive level
		logic [4:0][15:0] prot;            // Locked configuration words
		logic        rd_v;
		logic [15:0] rdata;
	} cmc_st_t;

	cmc_st_t st_q;   // Registered state
	cmc_st_t st_d;   // Next state

	logic idle;       // Bus idle seen
	logic rx_src;     // Receive level fed to the engine and detector
	logic is_cfg;
	logic wr_ctrl;
	logic wr_cfg2;
	logic req_legal;

	// Loopback feeds the engine its own transmit
	always_comb begin
		if (st_q.mode == CMC_LOOP)
			rx_src = eng_tx;
		else if (sleep && st_q.wake_filter_enable)
			rx_src = st_q.filt_level;
		else
			rx_src = bus_receive_pin;                                  // Filter bypassed
	end

	cmc_idle_det #(
		.IDLE_BITS(IDLE_BITS)
	) u_idle (
		.clk_sys (clk_sys),
		.rst     (rst),
		.bit_stb (bit_stb),
		.rx_level(rx_src),
		.idle    (idle)
	);

	assign is_cfg  = (st_q.mode == CMC_CONFIG);
	assign wr_ctrl = bus.wr && (bus.addr == `CMC_OFS_CTRL);
	assign wr_cfg2 = bus.wr && (bus.addr == `CMC_OFS_CFG2) && is_cfg;

	// Only the six defined codes are taken
	always_comb begin
		case (st_q.mode_request_field)
			`CMC_MODE_NORMAL, `CMC_MODE_DISABLE, `CMC_MODE_LOOP,
			`CMC_MODE_LISTEN, `CMC_MODE_CONFIG, `CMC_MODE_LALL: req_legal = 1'b1;
			default:                                            req_legal = 1'b0;
		endcase
	end

	// Next state
	always_comb begin
		st_d = st_q;
		st_d.rd_v = bus.rd;

		// Request field is always writable, else config could never be left
		if (wr_ctrl)
			st_d.mode_request_field = bus.wdata[`CMC_REQ_MSB:`CMC_REQ_LSB];
		if (wr_cfg2)
			st_d.wake_filter_enable = bus.wdata[`CMC_WAKFLT_BIT];
		// Locked words: filters, masks, timing
		if (bus.wr && is_cfg && bus.addr >= `CMC_OFS_PROT_LO && bus.addr <= `CMC_OFS_PROT_HI)
			st_d.prot[3'(bus.addr - `CMC_OFS_PROT_LO)] = bus.wdata;
		// Software clears wake, abort and capture flags by writing ones; a new set wins
		if (bus.wr && bus.addr == `CMC_OFS_STAT) begin
			if (bus.wdata[0]) st_d.wake_event_flag = 1'b0;
			if (bus.wdata[1]) st_d.transmit_aborted_flag = 1'b0;
			if (bus.wdata[2]) st_d.rx_cap_full = 1'b0;
		end

		// Wake filter: level must hold for WAKE_FILT cycles
		if (bus_receive_pin == st_q.filt_level)
			st_d.filt_cnt = 4'h0;
		else if (st_q.filt_cnt == 4'(WAKE_FILT - 1)) begin
			st_d.filt_cnt = 4'h0;
			st_d.filt_level = bus_receive_pin;
		end else
			st_d.filt_cnt = st_q.filt_cnt + 4'h1;

		// Transmit request from engine
		if (eng.tx_req && tx_allow && !st_q.transmit_request_flag)
			st_d.transmit_request_flag = 1'b1;
		if (tx_start)
			st_d.tx_wait = 1'b0;
		// Own run count, restarted on mode entry; the shared detector may already be saturated
		if (bit_stb) begin
			if (!rx_src)
				st_d.wait_cnt = 8'h00;
			else if (st_q.wait_cnt < 8'(IDLE_BITS))
				st_d.wait_cnt = st_q.wait_cnt + 8'h01;
		end

		// Error counters: frozen in listen-only, kept in disable
		if (st_q.mode == CMC_NORMAL || st_q.mode == CMC_LOOP) begin
			if (err_tx_inc && st_q.tec != 8'hFF) st_d.tec = st_q.tec + 8'h01;
			if (err_rx_inc && st_q.rec != 8'hFF) st_d.rec = st_q.rec + 8'h01;
		end

		// Partial frame capture in listen-all
		if (st_q.mode == CMC_LALL && eng.frame_err) begin
			st_d.rx_capture = eng.asm_data;
			st_d.rx_cap_full = 1'b1;
		end

		// Bus activity while disabled raises wake flag
		if (st_q.mode == CMC_DISABLE && !rx_src)
			st_d.wake_event_flag = 1'b1;

		// Disable requested during the first-frame wait aborts it
		if (st_q.tx_wait && st_q.transmit_request_flag && st_q.mode_request_field == `CMC_MODE_DISABLE) begin
			st_d.transmit_aborted_flag = 1'b1;
			st_d.transmit_request_flag = 1'b0;
			st_d.tx_wait = 1'b0;
		end else if (tx_start)
			st_d.transmit_request_flag = 1'b0;

		// Mode change only on idle bus and legal code
		if (req_legal && st_q.mode_request_field != st_q.mode && idle && !eng.rx_busy) begin
			if (!(st_q.mode_request_field == `CMC_MODE_CONFIG && eng.tx_busy)) begin
				st_d.mode = cmc_mode_t'(st_q.mode_request_field);
				if (st_q.mode_request_field == `CMC_MODE_CONFIG) begin
					st_d.tec = 8'h00;
					st_d.rec = 8'h00;
				end
				// New transmit-capable mode: first frame waits for a fresh idle run
				st_d.wait_cnt = 8'h00;
				st_d.tx_wait = (st_q.mode_request_field == `CMC_MODE_NORMAL) ||
				               (st_q.mode_request_field == `CMC_MODE_LOOP);
			end
		end

		// Read mux, data in the following cycle
		case (bus.addr)
			`CMC_OFS_CTRL:   st_d.rdata = {5'h00, st_q.mode_request_field, st_q.mode, 5'h00};
			`CMC_OFS_CFG2:   st_d.rdata = {1'b0, st_q.wake_filter_enable, 14'h0000};
			`CMC_OFS_STAT:   st_d.rdata = {12'h000, st_q.transmit_request_flag, st_q.rx_cap_full,
			                              st_q.transmit_aborted_flag, st_q.wake_event_flag};
			`CMC_OFS_ERRCNT: st_d.rdata = {st_q.tec, st_q.rec};
			`CMC_OFS_RXCAP:  st_d.rdata = st_q.rx_capture;
			default: begin
				if (bus.addr >= `CMC_OFS_PROT_LO && bus.addr <= `CMC_OFS_PROT_HI)
					st_d.rdata = st_q.prot[3'(bus.addr - `CMC_OFS_PROT_LO)];
				else
					st_d.rdata = 16'h0000;
			end
		endcase
		if (!bus.rd)
			st_d.rdata = 16'h0000;
	end

	// State register; reset lands in configuration
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q                    <= '0;
			st_q.mode_request_field <= `CMC_MODE_CONFIG;
			st_q.mode               <= CMC_CONFIG;
			st_q.filt_level         <= 1'b1;
		end else
			st_q <= st_d;
	end

	// Engine permissions per mode
	assign tx_allow      = (st_q.mode == CMC_NORMAL) || (st_q.mode == CMC_LOOP);
	assign rx_allow      = (st_q.mode != CMC_CONFIG) && (st_q.mode != CMC_DISABLE);
	assign err_ack_allow = tx_allow;
	assign ignore_err    = (st_q.mode == CMC_LALL);
	assign tx_start      = st_q.transmit_request_flag && tx_allow &&
	                       (!st_q.tx_wait || (st_q.wait_cnt >= 8'(IDLE_BITS)));
	assign eng_rx        = rx_src;
	assign rdata         = st_q.rdata;

	// Pin ownership: only normal mode drives transmit
	assign tx_pin_own       = (st_q.mode == CMC_NORMAL);
	assign rx_pin_own       = (st_q.mode != CMC_DISABLE) && (st_q.mode != CMC_LOOP);
	assign bus_transmit_pin = tx_pin_own ? eng_tx : 1'b1;

endmodule // cmc_mode_ctrl

`default_nettype wire

// File: src/cmc_regs.svh
// Constants for the CAN operating-mode controller: field positions, mode codes, counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

// Control and CFG2 word field positions
`define CMC_REQ_MSB      10
`define CMC_REQ_LSB      8
`define CMC_MODE_MSB     7
`define CMC_MODE_LSB     5
`define CMC_WAKFLT_BIT   14

// Mode codes
`define CMC_MODE_NORMAL  3'h0
`define CMC_MODE_DISABLE 3'h1
`define CMC_MODE_LOOP    3'h2
`define CMC_MODE_LISTEN  3'h3
`define CMC_MODE_CONFIG  3'h4
`define CMC_MODE_LALL    3'h7

// Register word offsets
`define CMC_OFS_CTRL     4'h0
`define CMC_OFS_CFG2     4'h1
`define CMC_OFS_STAT     4'h2
`define CMC_OFS_ERRCNT   4'h3
`define CMC_OFS_RXCAP    4'h4
`define CMC_OFS_PROT_LO  4'h5
`define CMC_OFS_PROT_HI  4'h9

// Idle bus detection
`define CMC_IDLE_BITS    11
// Wake filter length in clock cycles
`define CMC_WAKE_FILT    4

`endif

// File: src/cmc_pkg.sv
// Types for the CAN operating-mode controller.
// Assumes cmc_regs.svh is on the include path.
`include "cmc_regs.svh"

package cmc_pkg;

	// Operating modes
	typedef enum logic [2:0] {
		CMC_NORMAL  = `CMC_MODE_NORMAL,
		CMC_DISABLE = `CMC_MODE_DISABLE,
		CMC_LOOP    = `CMC_MODE_LOOP,
		CMC_LISTEN  = `CMC_MODE_LISTEN,
		CMC_CONFIG  = `CMC_MODE_CONFIG,
		CMC_LALL    = `CMC_MODE_LALL
	} cmc_mode_t;

	// Register bus request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} cmc_bus_t;

	// Events from the protocol engine
	typedef struct packed {
		logic        tx_busy;
		logic        rx_busy;
		logic        tx_req;
		logic        frame_err;
		logic [15:0] asm_data;
	} cmc_eng_t;

endpackage

// File: src/cmc_idle_det.sv
// Idle bus detector: counts consecutive recessive sampled bits.
// Assumes a one-cycle bit sample strobe and a receive level synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "cmc_regs.svh"

module cmc_idle_det #(
	parameter int IDLE_BITS = `CMC_IDLE_BITS
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Bit stream
	input  wire logic bit_stb,
	input  wire logic rx_level,
	// Result
	output logic      idle
);
	import cmc_pkg::*;

	initial begin
		if (IDLE_BITS < 1 || IDLE_BITS > 255)
			$error("cmc_idle_det: IDLE_BITS out of range");
	end

	typedef struct packed {
		logic [7:0] cnt;
	} cmc_idle_st_t;

	cmc_idle_st_t st_q;   // Registered state
	cmc_idle_st_t st_d;   // Next state

	// Recessive run length, saturating at the idle count
	always_comb begin
		st_d = st_q;
		if (bit_stb) begin
			if (!rx_level)
				st_d.cnt = 8'h00;                                   // Dominant restarts
			else if (st_q.cnt < 8'(IDLE_BITS))
				st_d.cnt = st_q.cnt + 8'h01;
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign idle = (st_q.cnt >= 8'(IDLE_BITS));

endmodule // cmc_idle_det

`default_nettype wire

// File: test/cmc_mode_ctrl_chk.sv
// Port checker for the mode controller.
// Assumes one clock domain; bound onto cmc_mode_ctrl below.
`timescale 1ns/1ns
`default_nettype none
module cmc_chk (
	// Clock and reset
	input wire logic              clk_sys,
	input wire logic              rst,
	// Register port
	input wire cmc_pkg::cmc_bus_t bus,
	input wire logic [15:0]       rdata,
	// Engine and pins
	input wire logic              bit_stb,
	input wire logic              eng_tx,
	input wire logic              sleep,
	input wire logic              eng_rx,
	input wire logic              tx_allow,
	input wire logic              rx_allow,
	input wire logic              err_ack_allow,
	input wire logic              tx_start,
	input wire logic              bus_receive_pin,
	input wire logic              bus_transmit_pin,
	input wire logic              tx_pin_own
);
	import cmc_pkg::*;
	localparam int IDLE_N = 11; // Recessive bits that make an idle bus
	logic [3:0] run_q;          // Own recessive run, saturates so idle stays seen
	// Count recessive samples, restart on dominant
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run_q <= 4'h0;
		end else if (bit_stb) begin
			run_q <= !bus_receive_pin ? 4'h0 : (run_q == 4'hF ? 4'hF : run_q + 4'h1);
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_no_read;
		!bus.rd;
	endsequence
	sequence s_idle_before;
		$past(run_q) >= IDLE_N;
	endsequence
	a_tx_pin_idle: assert property (!tx_pin_own |-> bus_transmit_pin)
		else $error("released transmit pin not recessive");
	a_tx_pin_follow: assert property (tx_pin_own |-> bus_transmit_pin == eng_tx)
		else $error("owned transmit pin does not follow engine");
	a_own_full: assert property (tx_pin_own |-> tx_allow && rx_allow)
		else $error("pin owned without transmit and receive");
	a_start_gate: assert property (tx_start |-> tx_allow)
		else $error("transmit start in a silent mode");
	a_ack_gate: assert property (!tx_allow |-> !err_ack_allow)
		else $error("acknowledge allowed without transmit");
	a_rdata_slot: assert property (s_no_read |=> rdata == 16'h0000)
		else $error("read data outside its slot");
	a_mode_idle: assert property ($changed({tx_allow, rx_allow, tx_pin_own}) |-> s_idle_before)
		else $error("mode changed without idle bus");
	a_loop_route: assert property (tx_allow && !tx_pin_own && !sleep |-> eng_rx == eng_tx)
		else $error("loopback receive not tied to transmit");
endmodule // cmc_chk
bind cmc_mode_ctrl cmc_chk u_cmc_chk (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
	.bit_stb(bit_stb), .eng_tx(eng_tx), .sleep(sleep), .eng_rx(eng_rx), .tx_allow(tx_allow),
	.rx_allow(rx_allow), .err_ack_allow(err_ack_allow), .tx_start(tx_start),
	.bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin), .tx_pin_own(tx_pin_own));
`default_nettype wire

// File: test/cmc_bus_node.sv
// Other nodes on the shared bus: bit strobes and a wired-AND level.
// Assumes the bench calls send_bits; the bus stands still between calls.
`timescale 1ns/1ns
`default_nettype none
module cmc_bus_node (
	// Clock
	input wire logic clk_sys,
	// Bus
	input wire logic bus_transmit_pin,
	output var logic bit_stb,
	output logic     bus_receive_pin
);
	logic node_lvl; // Level driven by the far nodes, 1 recessive
	initial begin
		node_lvl = 1'b1;
		bit_stb = 1'b0;
	end
	// Dominant wins; the pull-up leaves a released line recessive
	assign bus_receive_pin = node_lvl & bus_transmit_pin;
	// One bit every five cycles, strobe late in the bit
	task automatic send_bits(input int n, input logic lvl);
		repeat (n) begin
			@(posedge clk_sys);
			node_lvl <= lvl;
			repeat (3) @(posedge clk_sys);
			bit_stb <= 1'b1;
			@(posedge clk_sys);
			bit_stb <= 1'b0;
		end
		node_lvl <= 1'b1;
	endtask
endmodule // cmc_bus_node
`default_nettype wire

// File: test/cmc_mode_ctrl_tb.sv
// Bench for the mode controller: register calls with expected values.
// Assumes the checker is bound and the bus node model is compiled.
`timescale 1ns/1ns
`default_nettype none
module cmc_mode_ctrl_tb;
	import cmc_pkg::*;
	logic        clk_sys, rst, bit_stb, eng_tx, err_tx_inc, sleep, eng_rx, tx_allow, rx_allow;
	logic        err_ack_allow, tx_start, ignore_err, bus_receive_pin, bus_transmit_pin;
	logic        tx_pin_own, rx_pin_own;
	cmc_bus_t    bus;
	cmc_eng_t    eng;
	logic [15:0] rdata, d;
	int          err_total, check_count;
	// Mode table: code, tx owned, rx owned, errors ignored
	logic [2:0]  codes [5] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h0};
	logic [4:0]  txo = 5'b10000, rxo = 5'b11100, ign = 5'b01000;
	cmc_mode_ctrl u_cmc_mode_ctrl (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata), .eng(eng),
		.bit_stb(bit_stb), .eng_tx(eng_tx), .err_tx_inc(err_tx_inc), .err_rx_inc(1'b0), .sleep(sleep),
		.eng_rx(eng_rx), .tx_allow(tx_allow), .rx_allow(rx_allow), .err_ack_allow(err_ack_allow),
		.tx_start(tx_start), .ignore_err(ignore_err), .bus_receive_pin(bus_receive_pin),
		.bus_transmit_pin(bus_transmit_pin), .tx_pin_own(tx_pin_own), .rx_pin_own(rx_pin_own));
	cmc_bus_node u_node (.clk_sys(clk_sys), .bus_transmit_pin(bus_transmit_pin), .bit_stb(bit_stb),
		.bus_receive_pin(bus_receive_pin));
	always #10 clk_sys = ~clk_sys;
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= v;
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		@(posedge clk_sys);
		d = rdata;
	endtask
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({15'h0000, got}, {15'h0000, exp});
	endtask
	// Request a mode, then give the bus an idle stretch
	task automatic go(input logic [2:0] c);
		wr(4'h0, {5'h00, c, 8'h00});
		u_node.send_bits(11, 1'b1);
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic mode_is(input logic [2:0] c);
		rd(4'h0);
		cmp_word(d & 16'h07E0, {5'h00, c, c, 5'h00});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_sys);
		err_total++;
		tally_and_finish;
	end
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		bus = '0;
		eng = '0;
		eng_tx = 1'b1;
		err_tx_inc = 1'b0;
		sleep = 1'b0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		mode_is(3'h4);
		cmp_bit(tx_allow | rx_allow | tx_pin_own, 1'b0);
		wr(4'h5, 16'hA5A5);
		rd(4'h5);
		cmp_word(d, 16'hA5A5);
		// A dominant bit restarts the idle run
		wr(4'h0, 16'h0000);
		u_node.send_bits(10, 1'b1);
		u_node.send_bits(1, 1'b0);
		u_node.send_bits(10, 1'b1);
		rd(4'h0);
		cmp_word(d & 16'h00E0, 16'h0080);
		u_node.send_bits(1, 1'b1);
		repeat (2) @(posedge clk_sys);
		mode_is(3'h0);
		cmp_bit(tx_pin_own, 1'b1);
		wr(4'h5, 16'h1234);
		rd(4'h5);
		cmp_word(d, 16'hA5A5);
		@(posedge clk_sys);
		err_tx_inc <= 1'b1;
		@(posedge clk_sys);
		err_tx_inc <= 1'b0;
		go(3'h5);
		rd(4'h0);
		cmp_word(d & 16'h07E0, 16'h0500);
		// Configuration waits for the running transmission
		eng.tx_busy <= 1'b1;
		go(3'h4);
		rd(4'h0);
		cmp_word(d & 16'h00E0, 16'h0000);
		eng.tx_busy <= 1'b0;
		u_node.send_bits(1, 1'b1);
		repeat (2) @(posedge clk_sys);
		mode_is(3'h4);
		rd(4'h3);
		cmp_word(d, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			go(codes[i]);
			mode_is(codes[i]);
			cmp_bit(tx_pin_own, txo[i]);
			cmp_bit(rx_pin_own, rxo[i]);
			cmp_bit(ignore_err, ign[i]);
			@(posedge clk_sys);
			eng_tx <= 1'b0;
			@(posedge clk_sys);
			eng_tx <= 1'b1;
			if (codes[i] == 3'h1) begin
				u_node.send_bits(2, 1'b0);
				rd(4'h2);
				cmp_bit(d[0], 1'b1);
			end
			if (codes[i] == 3'h7) begin
				@(posedge clk_sys);
				eng.asm_data <= 16'hBEEF;
				eng.frame_err <= 1'b1;
				@(posedge clk_sys);
				eng.frame_err <= 1'b0;
				rd(4'h4);
				cmp_word(d, 16'hBEEF);
			end
		end
		// Disable during the first-transmit wait aborts it
		go(3'h3);
		wr(4'h0, 16'h0000);
		eng.tx_req <= 1'b1;
		wr(4'h0, 16'h0100);
		u_node.send_bits(11, 1'b1);
		eng.tx_req <= 1'b0;
		rd(4'h2);
		cmp_word(d & 16'h000A, 16'h0002);
		tally_and_finish;
	end
endmodule // cmc_mode_ctrl_tb
`default_nettype wire
